// file: reset_strap_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module reset_strap_sequencer
    import reset_seq_pkg::*;
#(
    parameter int SHORT_CYC = SHORT_DELAY_CYC,    // 100 us in cycles
    parameter int LONG_CYC  = LONG_DELAY_CYC      // 20 ms in cycles
)
(
    input  wire logic       mclk,
    input  wire logic       reset_n,              // External reset, async low
    input  wire logic       clk_en,               // Freezes all state when low
    input  wire logic       delay_strap,          // Pin: delay select
    input  wire logic       width_strap,          // Pin: bus width select
    input  wire logic       major_sel,            // Control bit: 1 major
    input  wire logic [3:0] mux_out,              // Core drive for muxed pins
    output logic            reset_out_n,          // Reset output, low active
    output logic            core_run,             // Core released
    output logic            bus16,                // 1: 16-bit data bus
    output logic            long_delay,           // Latched delay strap
    output logic            boot_sel_n,           // Boot select 0
    output logic            boot_sel_oe_n,        // Boot select enable, low drives
    output logic [3:0]      mux_pin_o,            // addr27..30_or_sel7..4_n data
    output logic [3:0]      mux_pin_oe_n          // Low while driving
);

    // ------------------------------------------------------------
    // Strap synchronisers
    // ------------------------------------------------------------
    logic [1:0] dly_sync_r;    // Delay strap, two flops
    logic [1:0] wid_sync_r;    // Width strap, two flops
    logic       first_take;    // High on the enabled cycle that captures the straps, the third after release

    // Two flops before any logic reads the pins
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dly_sync_r <= 2'h0;
            wid_sync_r <= 2'h0;
        end
        else if (clk_en)
        begin
            dly_sync_r <= {dly_sync_r[0], delay_strap};
            wid_sync_r <= {wid_sync_r[0], width_strap};
        end
    end

    // ------------------------------------------------------------
    // Strap capture after release
    // ------------------------------------------------------------
    logic [1:0] cap_cnt_r;     // Waits for synchronisers to fill
    logic       captured_r;    // Straps taken

    // Counts two enabled edges so both sync stages hold pin data
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            cap_cnt_r <= 2'h0;
        else if (clk_en && cap_cnt_r != 2'h2)
            cap_cnt_r <= cap_cnt_r + 2'h1;
    end

    // Caught by a clocked process, never by the async reset itself
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            long_delay <= LONG_RST;
            bus16      <= BUS16_RST;
            captured_r <= 1'b0;
        end
        else if (clk_en && !captured_r && cap_cnt_r == 2'h2)
        begin
            long_delay <= dly_sync_r[1];
            bus16      <= wid_sync_r[1];
            captured_r <= 1'b1;
        end
    end

    assign first_take = clk_en && !captured_r && cap_cnt_r == 2'h2;

    // ------------------------------------------------------------
    // Delay counter and sequence
    // ------------------------------------------------------------
    seq_state_t       state_r;     // Sequence state
    logic [CNT_W-1:0] cnt_r;       // Elapsed delay cycles
    logic [CNT_W-1:0] term;        // Terminal count
    logic             start_r;     // Processing start pulse
    seq_if            pif ();

    assign term = long_delay ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);

    // Count only once straps are in, so the right limit is used
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= ST_DELAY;
            cnt_r   <= '0;
            start_r <= 1'b0;
        end
        else if (clk_en)
        begin
            start_r <= 1'b0;
            case (state_r)
                ST_DELAY:
                begin
                    if (captured_r && !first_take)
                    begin
                        if (cnt_r >= term)
                        begin
                            state_r <= ST_PROCESS;
                            start_r <= 1'b1;
                        end
                        else
                            cnt_r <= cnt_r + CNT_W'(1);
                    end
                end
                ST_PROCESS:
                begin
                    if (pif.done)
                        state_r <= ST_RUN;
                end
                ST_RUN:
                    state_r <= ST_RUN;
                default:
                    state_r <= ST_DELAY;
            endcase
        end
    end

    assign pif.start = start_r;
    assign pif.major = major_sel;

    reset_proc_timer u_proc (
        .mclk    (mclk),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .bus     (pif)
    );

    // ------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------
    logic rst_out_r;   // Registered reset output

    // Registered so a state decode glitch never reaches the pin
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            rst_out_r <= 1'b0;
        else if (clk_en)
            rst_out_r <= (state_r != ST_DELAY);
    end

    assign reset_out_n   = rst_out_r;
    assign core_run      = (state_r == ST_RUN);
    // Board pulls decide the pin level while released
    assign mux_pin_oe_n  = core_run ? 4'h0 : MUX_OE_OFF;
    assign mux_pin_o     = core_run ? mux_out : 4'h0;
    // Boot fetch from external memory needs select 0 asserted
    assign boot_sel_n    = 1'b0;
    assign boot_sel_oe_n = 1'b0;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    int unsigned hold_cnt_r;   // Cycles reset output has been low

    // Counts only enabled cycles, as the delay counter does
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            hold_cnt_r <= 0;
        else if (clk_en && !reset_out_n)
            hold_cnt_r <= hold_cnt_r + 1;
    end

    sequence s_rel;
        $rose(reset_out_n);
    endsequence

    // Processing launch, one sequence per length
    sequence s_minor_go;
        clk_en && start_r && !major_sel;
    endsequence

    sequence s_major_go;
        clk_en && start_r && major_sel;
    endsequence

    // Output release must wait for the strap-selected delay
    a_out_hold_len: assert property (@(posedge mclk) disable iff (!reset_n)
        s_rel |-> hold_cnt_r >= (long_delay ? LONG_CYC : SHORT_CYC))
        else $error("reset output too short");
    a_out_release: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && start_r |=> reset_out_n) else $error("reset output not released");
    a_mux_tristate: assert property (@(posedge mclk) disable iff (!reset_n)
        !core_run |-> mux_pin_oe_n == 4'hF) else $error("muxed pin driven in reset");
    a_mux_drive: assert property (@(posedge mclk) disable iff (!reset_n)
        core_run |-> mux_pin_oe_n == 4'h0 && mux_pin_o == mux_out)
        else $error("muxed pin not driven in run");
    a_boot_low: assert property (@(posedge mclk) disable iff (!reset_n)
        !core_run |-> !boot_sel_n && !boot_sel_oe_n) else $error("boot select not low");
    a_strap_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        captured_r && $past(captured_r) |-> $stable(bus16) && $stable(long_delay))
        else $error("strap changed after capture");
    a_run_after: assert property (@(posedge mclk) disable iff (!reset_n)
        core_run |-> reset_out_n) else $error("run before reset output released");
    a_run_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        core_run |=> core_run) else $error("core run dropped");
    // Done shows one cycle after the last counted processing cycle
    a_proc_minor: assert property (@(posedge mclk) disable iff (!reset_n)
        s_minor_go ##1 clk_en[*5] |-> pif.done) else $error("minor processing length wrong");
    a_proc_major: assert property (@(posedge mclk) disable iff (!reset_n)
        s_major_go ##1 clk_en[*8] ##1 clk_en[*8] ##1 clk_en |-> pif.done)
        else $error("major processing length wrong");
    a_term_sel: assert property (@(posedge mclk) disable iff (!reset_n)
        start_r |-> cnt_r == (long_delay ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1)))
        else $error("terminal count mismatch");
    a_width_take: assert property (@(posedge mclk) disable iff (!reset_n)
        first_take |=> bus16 == $past(wid_sync_r[1])) else $error("width strap not taken");

endmodule
`default_nettype wire

// file: reset_seq_pkg.sv
// Notes on behaviour
// - Delay strap low 100 us, high 20 ms
// - Delay strap taken at reset rising edge; here taken on the third enabled clock after release
// - Width strap low 8-bit, high 16-bit
// - Reset output low for whole delay
// - After delay, major/minor processing, then run
// - Control bit picks major or minor processing
// - Muxed pins: address 27-30 or select 7-4
// - Muxed pins high-impedance while reset active
// - Boot select 0 driven low at reset
`default_nettype none
package reset_seq_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 10;         // 100 MHz core clock
    localparam int SHORT_DELAY_US    = 100;        // Strap low
    localparam int LONG_DELAY_MS     = 20;         // Strap high
    localparam int SHORT_DELAY_CYC   = (SHORT_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int LONG_DELAY_CYC    = (LONG_DELAY_MS * 1000000) / CLK_PERIOD_NS;
    localparam int MAJOR_PROC_CYC    = 16;         // Major processing length
    localparam int MINOR_PROC_CYC    = 4;          // Minor processing length
    localparam int CNT_W             = 24;         // Delay counter width

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic       BUS16_RST   = 1'b0;     // 8-bit until sampled
    localparam logic       LONG_RST    = 1'b0;     // Short until sampled
    localparam int         MUX_PINS    = 4;        // Muxed pin count
    localparam logic [3:0] MUX_OE_OFF  = 4'hF;     // All pins released

    typedef enum logic [1:0] {
        ST_DELAY,
        ST_PROCESS,
        ST_RUN
    } seq_state_t;

endpackage
`default_nettype wire

// file: seq_if.sv
`timescale 1ns/100ps
`default_nettype none
// Request and status between sequencer and processing timer
interface seq_if;
    logic start;   // One-cycle start pulse
    logic major;   // Major when high
    logic done;    // One-cycle completion pulse
    modport seq  (output start, output major, input done);
    modport proc (input start, input major, output done);
endinterface
`default_nettype wire

// file: reset_proc_timer.sv
`timescale 1ns/100ps
`default_nettype none
module reset_proc_timer
    import reset_seq_pkg::*;
(
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic clk_en,
    seq_if.proc       bus
);

    logic [4:0] left_r;   // Cycles remaining
    logic       busy_r;   // Processing in progress
    logic       done_r;   // Completion pulse

    // ------------------------------------------------------------
    // Major or minor processing countdown
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            left_r <= 5'h00;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end
        else if (clk_en)
        begin
            done_r <= 1'b0;
            if (bus.start)
            begin
                // Major sequence is longer: it reinitialises more state
                left_r <= bus.major ? 5'(MAJOR_PROC_CYC - 1) : 5'(MINOR_PROC_CYC - 1);
                busy_r <= 1'b1;
            end
            else if (busy_r)
            begin
                if (left_r == 5'h00)
                begin
                    busy_r <= 1'b0;
                    done_r <= 1'b1;
                end
                else
                begin
                    left_r <= left_r - 5'h01;
                end
            end
        end
    end

    assign bus.done = done_r;

endmodule
`default_nettype wire

// file: reset_board_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Board side: pull resistors on the muxed pins
// ------------------------------------------------------------
module reset_board_model
(
    input  wire logic [3:0] pin_o,      // Device drive data
    input  wire logic [3:0] pin_oe_n,   // Device enables, low drives
    input  wire logic [3:0] pull_up,    // 1: pulled high (select use)
    output logic      [3:0] pin_lvl     // Resolved wire level
);
    // Released pin settles to its pull, never to a stale value
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            pin_lvl[i] = pin_oe_n[i] ? pull_up[i] : pin_o[i];
        end
    end
endmodule
`default_nettype wire

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
    import reset_seq_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int SC = 20;     // Short delay, shortened
    localparam int LC = 50;     // Long delay, shortened
    logic       mclk, reset_n, clk_en, delay_strap, width_strap, major_sel;
    logic [3:0] mux_out, mux_pin_o, mux_pin_oe_n, pulls, pin_lvl;
    logic       reset_out_n, core_run, bus16, long_delay, boot_sel_n, boot_sel_oe_n;
    int         err_total, checks_done, cyc;
    integer     seed;

    reset_strap_sequencer #(.SHORT_CYC(SC), .LONG_CYC(LC)) i_dut (
        .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
        .delay_strap(delay_strap), .width_strap(width_strap), .major_sel(major_sel),
        .mux_out(mux_out), .reset_out_n(reset_out_n), .core_run(core_run),
        .bus16(bus16), .long_delay(long_delay), .boot_sel_n(boot_sel_n),
        .boot_sel_oe_n(boot_sel_oe_n), .mux_pin_o(mux_pin_o),
        .mux_pin_oe_n(mux_pin_oe_n));
    reset_board_model i_board (
        .pin_o(mux_pin_o), .pin_oe_n(mux_pin_oe_n), .pull_up(pulls), .pin_lvl(pin_lvl));

    // ------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Ceiling well above sixteen long runs
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            err_total++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // Compare and report tasks
    // ------------------------------------------------------------
    task automatic check_val(input logic [3:0] got, input logic [3:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Counts are bench integers, so a window test is enough
    task automatic check_rng(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi)
        begin
            err_total++;
            $display("wrong value t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic conclude();
        $display("errors=%0d checks=%0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic int proc_len(input logic m);
        return m ? MAJOR_PROC_CYC : MINOR_PROC_CYC;
    endfunction

    // ------------------------------------------------------------
    // One full reset sequence, straps flipped after capture
    // ------------------------------------------------------------
    task automatic run_seq(input logic d, input logic w, input logic m, input int stall);
        int n;
        int base;
        reset_n = 1'b0;
        delay_strap = d;
        width_strap = w;
        major_sel = m;
        pulls = 4'($random(seed));
        repeat (6) @(negedge mclk);     // Scaled supervisor hold
        check_val({reset_out_n, core_run, boot_sel_n, boot_sel_oe_n}, 4'h0);
        check_val(mux_pin_oe_n, 4'hF);
        check_val(pin_lvl, pulls);
        reset_n = 1'b1;
        n = 0;
        base = d ? LC : SC;
        while (reset_out_n !== 1'b1 && n < 500)
        begin
            @(negedge mclk);
            n++;
            if (n == 6)
            begin
                delay_strap = ~d;
                width_strap = ~w;
            end
            clk_en = !(n > 8 && n <= 8 + stall);
            check_val(mux_pin_oe_n, 4'hF);
        end
        check_rng(n, base + stall + 2, base + stall + 8);
        check_val({2'h0, long_delay, bus16}, {2'h0, d, w});
        n = 0;
        while (core_run !== 1'b1 && n < 100)
        begin
            @(negedge mclk);
            n++;
        end
        check_rng(n, proc_len(m) - 1, proc_len(m) + 4);
        mux_out = 4'($random(seed));
        @(negedge mclk);
        check_val(mux_pin_oe_n, 4'h0);
        check_val(pin_lvl, mux_out);
        check_val({reset_out_n, core_run, boot_sel_n, boot_sel_oe_n}, 4'hC);
        check_val({2'h0, long_delay, bus16}, {2'h0, d, w});
    endtask

    // ------------------------------------------------------------
    // Main sequence: all strap corners, abort, stall, random runs
    // ------------------------------------------------------------
    initial
    begin
        err_total = 0;
        checks_done = 0;
        cyc = 0;
        seed = 32'h71DF;
        reset_n = 1'b0;
        clk_en = 1'b1;
        delay_strap = 1'b0;
        width_strap = 1'b0;
        major_sel = 1'b0;
        mux_out = 4'h0;
        pulls = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            run_seq(i[0], i[1], i[2], (i == 3) ? 10 : 0);
        end
        // Reset again in mid-count: everything falls back at once
        reset_n = 1'b0;
        delay_strap = 1'b1;
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        repeat (12) @(negedge mclk);
        check_val({2'h0, long_delay, reset_out_n}, 4'h2);
        reset_n = 1'b0;
        @(negedge mclk);
        check_val({reset_out_n, core_run, long_delay, bus16}, 4'h0);
        check_val(mux_pin_oe_n, 4'hF);
        for (int i = 0; i < 8; i++)
        begin
            run_seq(1'($random(seed)), 1'($random(seed)), 1'($random(seed)), 0);
        end
        conclude();
    end
endmodule
`default_nettype wire
